// >>> rtl/mipc_pkg.sv
// package for the mac interrupt pacing combiner: offsets, fields, timing
package mipc_pkg;
    // byte offsets on the slave register port
    localparam logic [7:0] OFF_CTRL = 8'h0C;
    localparam logic [7:0] OFF_RXLVL_EN = 8'h10;
    localparam logic [7:0] OFF_RECV_ENA = 8'h14;
    localparam logic [7:0] OFF_XMIT_ENA = 8'h18;
    localparam logic [7:0] OFF_MISC_ENA = 8'h1C;
    localparam logic [7:0] OFF_RXLVL_STAT = 8'h40;
    localparam logic [7:0] OFF_RECV_STS = 8'h44;
    localparam logic [7:0] OFF_XMIT_STS = 8'h48;
    localparam logic [7:0] OFF_MISC_STAT = 8'h4C;
    localparam logic [7:0] OFF_RX_LIMIT = 8'h70;
    localparam logic [7:0] OFF_TX_LIMIT = 8'h74;
    // interrupt control fields
    localparam int PACE_LSB = 16;
    localparam int PACE_W = 6;
    localparam int PACE_RX_BIT = 0;
    localparam int PACE_TX_BIT = 1;
    localparam int PRESC_W = 12;
    localparam int LIMIT_W = 6;
    localparam int NCHAN = 8;
    localparam int NMISC = 4;
    // reset values
    localparam logic [PRESC_W-1:0] PRESC_RST = 12'h000;
    localparam logic [PACE_W-1:0] PACE_RST = 6'h00;
    localparam logic [7:0] EN_RST = 8'h00;
    localparam logic [LIMIT_W-1:0] LIMIT_RST = 6'h00;
    // pacing time base: prescaler runs on clock/6, 250 ticks of 4 us form 1 ms
    localparam int CLK_DIV = 6;
    localparam int TICK_US = 4;
    localparam int WINDOW_US = 1000;
    localparam int TICKS_PER_MS = WINDOW_US / TICK_US;

    typedef struct packed {
        logic [NCHAN-1:0] rx_level;
        logic [NCHAN-1:0] rx;
        logic [NCHAN-1:0] tx;
        logic [NMISC-1:0] misc;
    } mipc_src_t;

    typedef struct packed {
        logic [PACE_W-1:0] pace_en;
        logic [PRESC_W-1:0] prescale;
    } mipc_ctrl_t;
endpackage

// >>> rtl/mipc_top.sv
// interrupt combining, masking and pacing for the mac subsystem
// Summary of operation
// - reserved bits in control, enable and status registers read zero.
// - pacing enable bit 0 paces receive pulse; clear bypasses pacing.
// - pacing enable bit 1 paces transmit pulse; clear bypasses pacing.
// - twelve-bit prescaler holds clock/6 periods per 4 us; pacing time base.
// - receive-level enables gate each channel onto the receive-level pulse.
// - receive enables gate each channel onto the receive pulse.
// - transmit enables gate each channel onto the transmit pulse.
// - misc enables gate stats, host error, link change, access done.
// - receive-level status shows enabled and active channels, read only.
// - receive status shows enabled active channels; writes ignored.
// - transmit status shows enabled active channels; writes ignored.
// - paced receive pulses limited to programmed count per millisecond.
// - paced transmit pulses limited to programmed count per millisecond.
`timescale 1ns/100ps
module mipc_top (
    input wire logic core_clk,
    input wire logic nrst,
    input wire mipc_pkg::mipc_src_t src,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    output logic [31:0] reg_rdata,
    output logic receive_level_pulse,
    output logic rx_pulse,
    output logic tx_pulse,
    output logic misc_pulse
);
    localparam int CW = 8;

    // control registers
    mipc_pkg::mipc_ctrl_t ctrl_r, ctrl_nxt;
    logic [7:0] lvl_en_r, lvl_en_nxt;
    logic [7:0] rx_ena_r, rx_ena_nxt;
    logic [7:0] tx_ena_r, tx_ena_nxt;
    logic [3:0] misc_ena_r, misc_ena_nxt;
    logic [5:0] rx_lim_r, rx_lim_nxt;
    logic [5:0] tx_lim_r, tx_lim_nxt;
    logic [31:0] rdata_r, rdata_nxt;

    // time base
    logic [2:0] div_r, div_nxt;
    logic [11:0] pre_r, pre_nxt;
    logic [CW-1:0] tick_cnt_r, tick_cnt_nxt;
    logic ms_end;
    logic tick;

    // pacing state
    logic [5:0] rx_cnt_r, rx_cnt_nxt;
    logic [5:0] tx_cnt_r, tx_cnt_nxt;
    logic rx_prev_r, rx_prev_nxt;
    logic tx_prev_r, tx_prev_nxt;
    logic rx_out_r, rx_out_nxt;
    logic tx_out_r, tx_out_nxt;
    logic lvl_out_r, lvl_out_nxt;
    logic misc_out_r, misc_out_nxt;

    logic [7:0] lvl_stat;
    logic [7:0] rx_masked;
    logic [7:0] tx_masked;
    logic [3:0] misc_stat;

    // pacer limit test: true while the count is under the limit, so a new request may pass
    function automatic logic pace_ok(input logic [5:0] cnt, input logic [5:0] lim);
        pace_ok = (cnt < lim);
    endfunction

    assign lvl_stat = src.rx_level & lvl_en_r;
    assign rx_masked = src.rx & rx_ena_r;
    assign tx_masked = src.tx & tx_ena_r;
    assign misc_stat = src.misc & misc_ena_r;

    assign tick = (div_r == 3'(mipc_pkg::CLK_DIV - 1)) && (pre_r == 12'h000);
    assign ms_end = tick && (tick_cnt_r == CW'(mipc_pkg::TICKS_PER_MS - 1));

    always_comb begin
        div_nxt = div_r;
        pre_nxt = pre_r;
        tick_cnt_nxt = tick_cnt_r;
        if (div_r == 3'(mipc_pkg::CLK_DIV - 1)) begin
            div_nxt = 3'h0;
            if (pre_r == 12'h000) begin
                pre_nxt = (ctrl_r.prescale == 12'h000) ? 12'h000 : ctrl_r.prescale - 12'h001;
            end else begin
                pre_nxt = pre_r - 12'h001;
            end
        end else begin
            div_nxt = div_r + 3'h1;
        end
        if (tick) begin
            tick_cnt_nxt = ms_end ? '0 : tick_cnt_r + CW'(1);
        end
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            div_r <= 3'h0;
            pre_r <= 12'h000;
            tick_cnt_r <= '0;
        end else begin
            div_r <= div_nxt;
            pre_r <= pre_nxt;
            tick_cnt_r <= tick_cnt_nxt;
        end
    end

    // pulse generation and pacing
    always_comb begin
        logic rx_any;
        logic tx_any;
        rx_any = |rx_masked;
        tx_any = |tx_masked;
        rx_cnt_nxt = ms_end ? 6'h00 : rx_cnt_r;
        tx_cnt_nxt = ms_end ? 6'h00 : tx_cnt_r;
        rx_prev_nxt = rx_any;
        tx_prev_nxt = tx_any;
        lvl_out_nxt = |lvl_stat;
        misc_out_nxt = |misc_stat;
        if (!ctrl_r.pace_en[mipc_pkg::PACE_RX_BIT]) begin
            rx_out_nxt = rx_any;
        end else begin
            rx_out_nxt = 1'b0;
            if (rx_any && pace_ok(rx_cnt_nxt, rx_lim_r)) begin
                rx_out_nxt = 1'b1;
                if (!rx_prev_r || !rx_out_r) begin
                    rx_cnt_nxt = rx_cnt_nxt + 6'h01;
                end
            end
            if (rx_out_r && rx_any) begin
                rx_out_nxt = 1'b1;
            end
        end
        if (!ctrl_r.pace_en[mipc_pkg::PACE_TX_BIT]) begin
            tx_out_nxt = tx_any;
        end else begin
            tx_out_nxt = 1'b0;
            if (tx_any && pace_ok(tx_cnt_nxt, tx_lim_r)) begin
                tx_out_nxt = 1'b1;
                if (!tx_prev_r || !tx_out_r) begin
                    tx_cnt_nxt = tx_cnt_nxt + 6'h01;
                end
            end
            if (tx_out_r && tx_any) begin
                tx_out_nxt = 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            rx_cnt_r <= 6'h00;
            tx_cnt_r <= 6'h00;
            rx_prev_r <= 1'b0;
            tx_prev_r <= 1'b0;
            rx_out_r <= 1'b0;
            tx_out_r <= 1'b0;
            lvl_out_r <= 1'b0;
            misc_out_r <= 1'b0;
        end else begin
            rx_cnt_r <= rx_cnt_nxt;
            tx_cnt_r <= tx_cnt_nxt;
            rx_prev_r <= rx_prev_nxt;
            tx_prev_r <= tx_prev_nxt;
            rx_out_r <= rx_out_nxt;
            tx_out_r <= tx_out_nxt;
            lvl_out_r <= lvl_out_nxt;
            misc_out_r <= misc_out_nxt;
        end
    end

    assign receive_level_pulse = lvl_out_r;
    assign rx_pulse = rx_out_r;
    assign tx_pulse = tx_out_r;
    assign misc_pulse = misc_out_r;

    // register writes; status offsets take no write
    always_comb begin
        ctrl_nxt = ctrl_r;
        lvl_en_nxt = lvl_en_r;
        rx_ena_nxt = rx_ena_r;
        tx_ena_nxt = tx_ena_r;
        misc_ena_nxt = misc_ena_r;
        rx_lim_nxt = rx_lim_r;
        tx_lim_nxt = tx_lim_r;
        if (reg_wr) begin
            case (reg_addr)
                mipc_pkg::OFF_CTRL: begin
                    ctrl_nxt.pace_en = reg_wdata[mipc_pkg::PACE_LSB +: mipc_pkg::PACE_W];
                    ctrl_nxt.prescale = reg_wdata[mipc_pkg::PRESC_W-1:0];
                end
                mipc_pkg::OFF_RXLVL_EN: lvl_en_nxt = reg_wdata[7:0];
                mipc_pkg::OFF_RECV_ENA: rx_ena_nxt = reg_wdata[7:0];
                mipc_pkg::OFF_XMIT_ENA: tx_ena_nxt = reg_wdata[7:0];
                mipc_pkg::OFF_MISC_ENA: misc_ena_nxt = reg_wdata[3:0];
                mipc_pkg::OFF_RX_LIMIT: rx_lim_nxt = reg_wdata[5:0];
                mipc_pkg::OFF_TX_LIMIT: tx_lim_nxt = reg_wdata[5:0];
                default: begin
                end
            endcase
        end
    end

    // read mux; reserved bits zero
    always_comb begin
        rdata_nxt = rdata_r;
        if (reg_rd) begin
            rdata_nxt = 32'h0000_0000;
            case (reg_addr)
                mipc_pkg::OFF_CTRL: begin
                    rdata_nxt[mipc_pkg::PACE_LSB +: mipc_pkg::PACE_W] = ctrl_r.pace_en;
                    rdata_nxt[mipc_pkg::PRESC_W-1:0] = ctrl_r.prescale;
                end
                mipc_pkg::OFF_RXLVL_EN: rdata_nxt[7:0] = lvl_en_r;
                mipc_pkg::OFF_RECV_ENA: rdata_nxt[7:0] = rx_ena_r;
                mipc_pkg::OFF_XMIT_ENA: rdata_nxt[7:0] = tx_ena_r;
                mipc_pkg::OFF_MISC_ENA: rdata_nxt[3:0] = misc_ena_r;
                mipc_pkg::OFF_RXLVL_STAT: rdata_nxt[7:0] = lvl_stat;
                mipc_pkg::OFF_RECV_STS: rdata_nxt[7:0] = rx_masked;
                mipc_pkg::OFF_XMIT_STS: rdata_nxt[7:0] = tx_masked;
                mipc_pkg::OFF_MISC_STAT: rdata_nxt[3:0] = misc_stat;
                mipc_pkg::OFF_RX_LIMIT: rdata_nxt[5:0] = rx_lim_r;
                mipc_pkg::OFF_TX_LIMIT: rdata_nxt[5:0] = tx_lim_r;
                default: rdata_nxt = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            ctrl_r <= '{pace_en: mipc_pkg::PACE_RST, prescale: mipc_pkg::PRESC_RST};
            lvl_en_r <= mipc_pkg::EN_RST;
            rx_ena_r <= mipc_pkg::EN_RST;
            tx_ena_r <= mipc_pkg::EN_RST;
            misc_ena_r <= mipc_pkg::EN_RST[3:0];
            rx_lim_r <= mipc_pkg::LIMIT_RST;
            tx_lim_r <= mipc_pkg::LIMIT_RST;
            rdata_r <= 32'h0000_0000;
        end else begin
            ctrl_r <= ctrl_nxt;
            lvl_en_r <= lvl_en_nxt;
            rx_ena_r <= rx_ena_nxt;
            tx_ena_r <= tx_ena_nxt;
            misc_ena_r <= misc_ena_nxt;
            rx_lim_r <= rx_lim_nxt;
            tx_lim_r <= tx_lim_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    assign reg_rdata = rdata_r;
endmodule // mipc_top

// >>> test/mipc_assertions.sv
// port checker for the interrupt combiner
`timescale 1ns/100ps
module mipc_assertions (
    input wire logic core_clk,
    input wire logic nrst,
    input wire mipc_pkg::mipc_src_t src,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic [31:0] reg_rdata,
    input wire logic receive_level_pulse,
    input wire logic rx_pulse,
    input wire logic tx_pulse,
    input wire logic misc_pulse
);
    logic [7:0] en_r [4];
    logic [7:0] en_nxt [4];
    logic [1:0] pace_r;
    logic [1:0] pace_nxt;
    logic [5:0] lim_r;
    logic [5:0] lim_nxt;
    // shadow of enables, pacing bits and receive limit
    always_comb begin
        en_nxt = en_r;
        pace_nxt = pace_r;
        lim_nxt = lim_r;
        if (reg_wr && reg_addr[7:4] == 4'h1) begin
            en_nxt[reg_addr[3:2]] = reg_wdata[7:0];
        end
        if (reg_wr && reg_addr == mipc_pkg::OFF_CTRL) begin
            pace_nxt = reg_wdata[17:16];
        end
        if (reg_wr && reg_addr == mipc_pkg::OFF_RX_LIMIT) begin
            lim_nxt = reg_wdata[5:0];
        end
    end
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            en_r <= '{default: 8'h00};
            pace_r <= 2'h0;
            lim_r <= 6'h00;
        end else begin
            en_r <= en_nxt;
            pace_r <= pace_nxt;
            lim_r <= lim_nxt;
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);
    a_level_mask: assert property ($past(nrst) |->
        receive_level_pulse == |($past(src.rx_level) & $past(en_r[0]))) else $error("level pulse");
    a_misc_mask: assert property ($past(nrst) |->
        misc_pulse == |($past(src.misc) & $past(en_r[3][3:0]))) else $error("misc pulse");
    a_rx_bypass: assert property ($past(nrst) && !$past(pace_r[0]) |->
        rx_pulse == |($past(src.rx) & $past(en_r[1]))) else $error("rx bypass");
    a_tx_bypass: assert property ($past(nrst) && !$past(pace_r[1]) |->
        tx_pulse == |($past(src.tx) & $past(en_r[2]))) else $error("tx bypass");
    a_rx_needs_source: assert property (rx_pulse |->
        |($past(src.rx) & $past(en_r[1]))) else $error("rx pulse without source");
    a_rx_limit_zero: assert property ($rose(rx_pulse) |->
        !($past(pace_r[0]) && $past(lim_r) == 6'h00)) else $error("rx pulse at limit zero");
    a_reserved_zero: assert property (
        reg_rdata[31:22] == 10'h000 && reg_rdata[15:12] == 4'h0) else $error("reserved bits");
    a_rx_status: assert property ($past(nrst) && $past(reg_rd)
        && $past(reg_addr) == mipc_pkg::OFF_RECV_STS |-> reg_rdata[7:0]
        == ($past(src.rx) & $past(en_r[1]))) else $error("rx status");
    a_tx_status: assert property ($past(nrst) && $past(reg_rd)
        && $past(reg_addr) == mipc_pkg::OFF_XMIT_STS |-> reg_rdata[7:0]
        == ($past(src.tx) & $past(en_r[2]))) else $error("tx status");
    c_rx_paced: cover property (pace_r[0] && $rose(rx_pulse));
    c_tx_rise: cover property ($rose(tx_pulse));
    c_misc_rise: cover property ($rose(misc_pulse));
endmodule // mipc_assertions
bind mipc_top mipc_assertions chk (.core_clk, .nrst, .src, .reg_wr, .reg_rd, .reg_addr,
    .reg_wdata, .reg_rdata, .receive_level_pulse, .rx_pulse, .tx_pulse, .misc_pulse);

// >>> test/mipc_pic_model.sv
// interrupt controller model: counts pulse rises
`timescale 1ns/100ps
module mipc_pic_model (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic rx_pulse,
    input wire logic tx_pulse,
    output logic [15:0] rx_rises,
    output logic [15:0] tx_rises
);
    logic rx_q;
    logic tx_q;
    always_ff @(posedge core_clk) begin
        rx_q <= rx_pulse;
        tx_q <= tx_pulse;
        if (!nrst) begin
            rx_rises <= 16'h0000;
            tx_rises <= 16'h0000;
        end else begin
            rx_rises <= rx_rises + {15'h0, rx_pulse & ~rx_q};
            tx_rises <= tx_rises + {15'h0, tx_pulse & ~tx_q};
        end
    end
endmodule // mipc_pic_model

// >>> test/tb_mac_interrupt_pacing_combiner.sv
// bench for the interrupt combiner
`timescale 1ns/100ps
module tb_mac_interrupt_pacing_combiner;
    typedef struct packed {
        logic [7:0] en;
        mipc_pkg::mipc_src_t s;
        logic [3:0] pul;
    } mipc_row_t;
    logic core_clk = 1'b0;
    logic nrst = 1'b0;
    mipc_pkg::mipc_src_t src = '0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic [31:0] reg_rdata;
    logic receive_level_pulse;
    logic rx_pulse;
    logic tx_pulse;
    logic misc_pulse;
    logic [15:0] rx_rises;
    logic [15:0] tx_rises;
    logic [15:0] rx0;
    logic [15:0] tx0;
    int bad_count = 0;
    int compares = 0;
    logic [7:0] offs [9] = '{8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h40, 8'h70, 8'h74, 8'h20};
    mipc_row_t rows [5] = '{'{8'h00, 28'hFFFFFFF, 4'h0}, '{8'hFF, 28'h0000000, 4'h0},
        '{8'h01, 28'h0100000, 4'h8}, '{8'h81, 28'h0280021, 4'h5},
        '{8'h0F, 28'hF008048, 4'h7}};
    mipc_top dut (.core_clk, .nrst, .src, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
        .reg_rdata, .receive_level_pulse, .rx_pulse, .tx_pulse, .misc_pulse);
    mipc_pic_model pic (.core_clk, .nrst, .rx_pulse, .tx_pulse, .rx_rises, .tx_rises);
    initial begin
        forever #12.5 core_clk = ~core_clk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
        #2;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        cyc(1);
        reg_wr = 1'b0;
        cyc(1);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        reg_rd = 1'b1;
        reg_addr = a;
        cyc(1);
        reg_rd = 1'b0;
        cyc(1);
        chk(reg_rdata, exp);
    endtask
    task automatic reset_dut;
        nrst = 1'b0;
        cyc(5);
        nrst = 1'b1;
    endtask
    task automatic pace_run(input logic [31:0] ctrl, input int lo, input int hi, input int txn);
        reset_dut();
        wr(mipc_pkg::OFF_RECV_ENA, 32'h1);
        wr(mipc_pkg::OFF_XMIT_ENA, 32'h1);
        wr(mipc_pkg::OFF_RX_LIMIT, 32'h2);
        wr(mipc_pkg::OFF_CTRL, ctrl);
        rx0 = rx_rises;
        tx0 = tx_rises;
        repeat (1500) begin
            src = 28'h0001010;
            cyc(2);
            src = '0;
            cyc(2);
        end
        cyc(2);
        chk(32'(int'(rx_rises - rx0) inside {[lo:hi]}), 32'h1);
        chk({16'h0, tx_rises - tx0}, 32'(txn));
    endtask
    task automatic finish_test;
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        #600000;
        bad_count++;
        finish_test();
    end
    initial begin
        reset_dut();
        foreach (offs[i]) rd(offs[i], 32'h0);
        foreach (rows[i]) begin
            for (int k = 0; k < 4; k++) wr(8'h10 + 8'(4 * k), {24'h0, rows[i].en});
            src = rows[i].s;
            cyc(2);
            chk({receive_level_pulse, rx_pulse, tx_pulse, misc_pulse}, rows[i].pul);
            rd(mipc_pkg::OFF_RXLVL_STAT, {24'h0, rows[i].s.rx_level & rows[i].en});
            rd(mipc_pkg::OFF_RECV_STS, {24'h0, rows[i].s.rx & rows[i].en});
            rd(mipc_pkg::OFF_XMIT_STS, {24'h0, rows[i].s.tx & rows[i].en});
        end
        for (int b = 0; b < 4; b++) begin
            wr(mipc_pkg::OFF_MISC_ENA, 32'(1 << b));
            src.misc = 4'hF ^ 4'(1 << b);
            cyc(2);
            chk({31'h0, misc_pulse}, 32'h0);
            src.misc = 4'(1 << b);
            cyc(2);
            chk({31'h0, misc_pulse}, 32'h1);
            rd(mipc_pkg::OFF_MISC_STAT, 32'(1 << b));
        end
        src = '0;
        wr(mipc_pkg::OFF_CTRL, 32'hFFFF_FFFF);
        rd(mipc_pkg::OFF_CTRL, 32'h003F_0FFF);
        wr(mipc_pkg::OFF_RECV_ENA, 32'hFFFF_FFFF);
        rd(mipc_pkg::OFF_RECV_ENA, 32'h0000_00FF);
        wr(mipc_pkg::OFF_TX_LIMIT, 32'hFFFF_FFFF);
        rd(mipc_pkg::OFF_TX_LIMIT, 32'h0000_003F);
        wr(mipc_pkg::OFF_RECV_STS, 32'hFFFF_FFFF);
        rd(mipc_pkg::OFF_RECV_STS, 32'h0);
        wr(8'h20, 32'hFFFF_FFFF);
        rd(8'h20, 32'h0);
        pace_run(32'h0001_0000, 7, 10, 1500);
        pace_run(32'h0003_0003, 2, 4, 0);
        // receive limit zero blocks every new pulse
        wr(mipc_pkg::OFF_RX_LIMIT, 32'h0);
        rx0 = rx_rises;
        src = 28'h0001010;
        cyc(2);
        src = '0;
        cyc(2);
        chk({16'h0, rx_rises - rx0}, 32'h0);
        finish_test();
    end
endmodule // tb_mac_interrupt_pacing_combiner
